// file: design/lhi_defines.svh
// constants of the lcd host port: bit positions, reset values, counts
// assumes inclusion by bare name from every design file that needs them
`ifndef LHI_DEFINES_SVH
`define LHI_DEFINES_SVH

// width of the host data bus
`define LHI_BUS_W 8
// status byte: busy on bit 7, all other bits zero
`define LHI_STATUS_BUSY_BIT 7
`define LHI_STATUS_REST 7'h00
// bit counter value on the eighth serial clock edge
`define LHI_SER_LAST_BIT 3'h7
`define LHI_SER_CNT_RST 3'h0
`define LHI_SER_SHIFT_RST 8'h00
// reset values of output registers
`define LHI_DOUT_RST 8'h00
`define LHI_HOLDER_RST 8'h00
`define LHI_OE_N_RST 8'hff
// entries of the write buffer
`define LHI_BUF_DEPTH 2
// number of pin bits passing the synchroniser
`define LHI_PIN_W 15

`endif

// file: design/lhi_pkg.sv
// types shared by the lcd host port modules
// assumes nothing beyond a SystemVerilog compiler
package lhi_pkg;

    // one byte handed to internal processing, tagged data or command
    typedef struct packed {
        logic isData;
        logic [7:0] data;
    } lhi_word_t;

    // parallel access sequencer
    typedef enum logic [1:0] {
        LHI_IDLE,
        LHI_READ,
        LHI_WRITE
    } lhi_acc_t;

endpackage

// file: design/lhi_word_if.sv
// valid/ready carrier for tagged bytes between the host port modules
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface lhi_word_if;
    logic valid;
    logic ready;
    lhi_pkg::lhi_word_t word;

    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface

// file: design/lhi_word_buf.sv
// small fifo of tagged bytes with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`include "lhi_defines.svh"
module lhi_word_buf #(
    parameter int DEPTH = `LHI_BUF_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // filling and draining sides
    lhi_word_if.snk fill,
    lhi_word_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    lhi_pkg::lhi_word_t mem_r [DEPTH];
    lhi_pkg::lhi_word_t mem_nxt [DEPTH];
    logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    // room for one more word whenever fewer than DEPTH are held
    assign fill.ready = (int'(count_r) < DEPTH);
    assign drain.valid = (count_r != '0);
    assign drain.word = mem_r[rdPtr_r];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
        ptrInc = (int'(p) == DEPTH - 1) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        mem_nxt = mem_r;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            mem_nxt[wrPtr_r] = fill.word;
            wrPtr_nxt = ptrInc(wrPtr_r);
        end
        if (pop) begin
            rdPtr_nxt = ptrInc(rdPtr_r);
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
        mem_r <= mem_nxt;
    end
endmodule

// file: design/lhi_serial_rx.sv
// serial byte receiver: shift register and bit counter, msb first
// assumes serial clock edges and data already synchronised to clock
`timescale 1ns/100ps
`include "lhi_defines.svh"
module lhi_serial_rx (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // synchronised serial inputs
    input wire logic enable,
    input wire logic sclRise,
    input wire logic sdi,
    input wire logic dcSel,
    // assembled bytes; no stall is possible on a write-only link
    lhi_word_if.src out
);
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] bitCnt_r, bitCnt_nxt;
    logic valid_r, valid_nxt;
    lhi_pkg::lhi_word_t word_r, word_nxt;

    assign out.valid = valid_r;
    assign out.word = word_r;

    always_comb begin
        shift_nxt = shift_r;
        bitCnt_nxt = bitCnt_r;
        valid_nxt = 1'b0;
        word_nxt = word_r;
        if (!enable) begin
            shift_nxt = `LHI_SER_SHIFT_RST; // see (R10)
            bitCnt_nxt = `LHI_SER_CNT_RST; // see (R10)
        end else if (sclRise) begin
            shift_nxt = {shift_r[6:0], sdi}; // see (R5) see (R6)
            bitCnt_nxt = bitCnt_r + 1'b1;
            if (bitCnt_r == `LHI_SER_LAST_BIT) begin
                valid_nxt = 1'b1; // see (R7)
                word_nxt.data = {shift_r[6:0], sdi};
                word_nxt.isData = dcSel; // see (R8) see (R9)
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_r <= `LHI_SER_SHIFT_RST;
            bitCnt_r <= `LHI_SER_CNT_RST;
            valid_r <= 1'b0;
            word_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            bitCnt_r <= bitCnt_nxt;
            valid_r <= valid_nxt;
            word_r <= word_nxt;
        end
    end
endmodule

// file: design/lhi_host_port.sv
// host port of a dot-matrix lcd driver: parallel 68/80 bus or serial input
// assumes all pins are asynchronous to clock; internal side runs on clock
//
// Function
// (R1) interface select high picks the 8-bit parallel bus, low picks serial input
// (R2) serial mode: bit 7 is data, bit 6 is clock, bits 5..0 stay undriven
// (R3) bus style high means enable plus read/write; low means low-active strobes
// (R4) select and direction decode into data read/write, status read, command write
// (R5) serial receiver is an eight-bit shift register with a three-bit counter
// (R6) serial bits sampled on rising serial clock, most significant bit first
// (R7) eighth rising serial clock hands the assembled byte onward
// (R8) serial byte is display data when select high, command when low
// (R9) data/command select is sampled on every eighth rising serial clock
// (R10) deselect clears shift register and bit counter, dropping partial bytes
// (R11) serial mode offers no read path at all
// (R12) accesses count only with active-low select low and active-high select high
// (R13) deselected: data lines undriven, select and strobes ignored
// (R14) status read returns busy on bit 7; while busy only status reads act; the serial receiver still takes bytes while busy
// (R15) display read returns the bus holder, then refills it; first read is dummy
// (R16) writes captured at the strobe's end; read data driven only during read
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "lhi_defines.svh"
module lhi_host_port (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // mode straps
    input wire logic parallelSelect,
    input wire logic busStyleSelect,
    // chip selects and access control pins
    input wire logic chipSelectActiveLowN,
    input wire logic chipSelectActiveHigh,
    input wire logic dataCommandSelect,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    // two-way data bus, enable low while driving
    input wire logic [`LHI_BUS_W-1:0] dataIn,
    output logic [`LHI_BUS_W-1:0] dataOut,
    output logic [`LHI_BUS_W-1:0] dataOeN,
    // bytes to internal processing
    output logic wordValid,
    input wire logic wordReady,
    output logic wordIsData,
    output logic [7:0] wordData,
    // internal state and display memory read side
    input wire logic busyIn,
    output logic ramReadReq,
    input wire logic [7:0] ramReadData
);
    // two-stage synchroniser for every pin input
    logic [`LHI_PIN_W-1:0] pinRaw, syncA_r, syncA_nxt, syncB_r, syncB_nxt;
    logic sclPrev_r, sclPrev_nxt;

    // synchronised pin levels
    logic parSel, busStyle, csN, cs, dcSel, rdPin, wrPin;
    logic [7:0] dIn;
    logic selected, parMode, serMode, sclRise;
    logic readAct, writeAct;
    logic busyFlag;

    // parallel access state
    lhi_pkg::lhi_acc_t acc_r, acc_nxt;
    logic [7:0] dout_r, dout_nxt;
    logic [7:0] oeN_r, oeN_nxt;
    logic [7:0] holder_r, holder_nxt;
    logic readIsData_r, readIsData_nxt;
    logic fetchReq_r, fetchReq_nxt;
    logic fetchDue_r, fetchDue_nxt;
    lhi_pkg::lhi_word_t wrWord_r, wrWord_nxt;
    logic wrRefused_r, wrRefused_nxt;
    logic parPush;

    // carriers between receiver, mux and buffer
    lhi_word_if serIf ();
    lhi_word_if bufIn ();
    lhi_word_if bufOut ();

    // returns {read, write} for the strobe pins in the chosen bus style
    function automatic logic [1:0] strobeDecode(input logic style68, input logic rd,
                                                input logic wr);
        if (style68) begin
            strobeDecode = {rd && wr, rd && !wr}; // see (R3)
        end else begin
            strobeDecode = {!rd, !wr}; // see (R3)
        end
    endfunction

    assign pinRaw = {parallelSelect, busStyleSelect, chipSelectActiveLowN,
                     chipSelectActiveHigh, dataCommandSelect, readStrobe,
                     writeStrobe, dataIn};

    always_comb begin
        syncA_nxt = pinRaw;
        syncB_nxt = syncA_r;
        sclPrev_nxt = syncB_r[6];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
            sclPrev_r <= 1'b0;
        end else begin
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
            sclPrev_r <= sclPrev_nxt;
        end
    end

    assign parSel = syncB_r[14];
    assign busStyle = syncB_r[13];
    assign csN = syncB_r[12];
    assign cs = syncB_r[11];
    assign dcSel = syncB_r[10];
    assign rdPin = syncB_r[9];
    assign wrPin = syncB_r[8];
    assign dIn = syncB_r[7:0];

    assign selected = !csN && cs; // see (R12)
    assign parMode = parSel; // see (R1)
    assign serMode = !parSel; // see (R1)
    assign sclRise = syncB_r[6] && !sclPrev_r; // see (R2) see (R6)
    assign {readAct, writeAct} = strobeDecode(busStyle, rdPin, wrPin);

    // a full buffer shows as busy so a parallel host holds off instead of losing bytes
    assign busyFlag = busyIn || !bufIn.ready;

    // parallel access sequencer
    always_comb begin
        acc_nxt = acc_r;
        dout_nxt = dout_r;
        oeN_nxt = `LHI_OE_N_RST;
        holder_nxt = holder_r;
        readIsData_nxt = readIsData_r;
        fetchReq_nxt = 1'b0;
        fetchDue_nxt = fetchReq_r;
        wrWord_nxt = wrWord_r;
        wrRefused_nxt = wrRefused_r;
        parPush = 1'b0;
        if (fetchDue_r) begin
            holder_nxt = ramReadData; // see (R15)
        end
        case (acc_r)
            lhi_pkg::LHI_IDLE: begin
                // serial mode or deselect: no bus drive, strobes ignored
                if (selected && parMode && readAct) begin // see (R11) see (R13)
                    readIsData_nxt = dcSel; // see (R4)
                    if (dcSel && busyFlag) begin
                        acc_nxt = lhi_pkg::LHI_READ; // see (R14)
                        readIsData_nxt = 1'b0;
                        dout_nxt = {busyFlag, `LHI_STATUS_REST};
                    end else if (dcSel) begin
                        acc_nxt = lhi_pkg::LHI_READ;
                        dout_nxt = holder_r; // see (R15)
                        oeN_nxt = 8'h00; // see (R16)
                    end else begin
                        acc_nxt = lhi_pkg::LHI_READ;
                        dout_nxt = {busyFlag, `LHI_STATUS_REST}; // see (R14)
                        oeN_nxt = 8'h00; // see (R16)
                    end
                    if (dcSel && busyFlag) begin
                        oeN_nxt = `LHI_OE_N_RST;
                    end
                end else if (selected && parMode && writeAct) begin
                    acc_nxt = lhi_pkg::LHI_WRITE;
                    wrWord_nxt.isData = dcSel;
                    wrWord_nxt.data = dIn;
                    wrRefused_nxt = busyFlag; // see (R14)
                end
            end
            lhi_pkg::LHI_READ: begin
                if (!selected || !parMode) begin
                    acc_nxt = lhi_pkg::LHI_IDLE; // see (R13)
                end else if (!readAct) begin
                    acc_nxt = lhi_pkg::LHI_IDLE;
                    fetchReq_nxt = readIsData_r; // see (R15)
                end else begin
                    oeN_nxt = oeN_r;
                    if (!readIsData_r) begin
                        dout_nxt = {busyFlag, `LHI_STATUS_REST};
                    end
                end
            end
            lhi_pkg::LHI_WRITE: begin
                if (!selected || !parMode) begin
                    acc_nxt = lhi_pkg::LHI_IDLE; // see (R13)
                end else if (!writeAct) begin
                    acc_nxt = lhi_pkg::LHI_IDLE;
                    parPush = !wrRefused_r; // see (R16)
                end else begin
                    wrWord_nxt.isData = dcSel; // see (R4) see (R16)
                    wrWord_nxt.data = dIn;
                end
            end
            default: begin
                acc_nxt = lhi_pkg::LHI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            acc_r <= lhi_pkg::LHI_IDLE;
            dout_r <= `LHI_DOUT_RST;
            oeN_r <= `LHI_OE_N_RST;
            holder_r <= `LHI_HOLDER_RST;
            readIsData_r <= 1'b0;
            fetchReq_r <= 1'b0;
            fetchDue_r <= 1'b0;
            wrWord_r <= '0;
            wrRefused_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            dout_r <= dout_nxt;
            oeN_r <= oeN_nxt;
            holder_r <= holder_nxt;
            readIsData_r <= readIsData_nxt;
            fetchReq_r <= fetchReq_nxt;
            fetchDue_r <= fetchDue_nxt;
            wrWord_r <= wrWord_nxt;
            wrRefused_r <= wrRefused_nxt;
        end
    end

    assign dataOut = dout_r;
    assign dataOeN = oeN_r; // see (R2) see (R13)
    assign ramReadReq = fetchReq_r;

    lhi_serial_rx u_serial (
        .clock(clock),
        .rst(rst),
        .enable(selected && serMode), // see (R10) see (R12)
        .sclRise(sclRise),
        .sdi(syncB_r[7]),
        .dcSel(dcSel),
        .out(serIf)
    );

    // only one source is live at a time, chosen by the interface strap
    assign bufIn.valid = parMode ? parPush : serIf.valid;
    assign bufIn.word = parMode ? wrWord_r : serIf.word;
    assign serIf.ready = bufIn.ready;

    lhi_word_buf #(
        .DEPTH(`LHI_BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .rst(rst),
        .fill(bufIn),
        .drain(bufOut)
    );

    assign wordValid = bufOut.valid;
    assign wordIsData = bufOut.word.isData;
    assign wordData = bufOut.word.data;
    assign bufOut.ready = wordReady;
endmodule

// file: testbench/lhi_host_port_chk.sv
// pin-level assertions of the lcd host port
// assumes binding onto lhi_host_port; pins pass a two-flop synchroniser
`timescale 1ns/100ps
module lhi_host_port_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // straps and access pins
    input wire logic parallelSelect,
    input wire logic busStyleSelect,
    input wire logic chipSelectActiveLowN,
    input wire logic dataCommandSelect,
    input wire logic readStrobe,
    // data bus outputs
    input wire logic [7:0] dataOut,
    input wire logic [7:0] dataOeN,
    // internal side
    input wire logic wordValid,
    input wire logic wordReady,
    input wire logic wordIsData,
    input wire logic [7:0] wordData,
    input wire logic busyIn,
    input wire logic ramReadReq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_rst;
        $past(rst) |-> dataOeN == 8'hff && dataOut == 8'h00 && !wordValid && !ramReadReq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset values");
    property p_desel;
        chipSelectActiveLowN [*5] |-> dataOeN == 8'hff;
    endproperty
    a_desel: assert property (p_desel) else $error("bus driven while deselected");
    property p_serial;
        !parallelSelect [*5] |-> dataOeN == 8'hff;
    endproperty
    a_serial: assert property (p_serial) else $error("bus driven in serial mode");
    property p_idle;
        (readStrobe != busStyleSelect) [*5] |-> dataOeN == 8'hff;
    endproperty
    a_idle: assert property (p_idle) else $error("bus driven without read");
    property p_status;
        (!dataCommandSelect && busyIn) [*5] ##0 dataOeN == 8'h00 |-> dataOut == 8'h80;
    endproperty
    a_status: assert property (p_status) else $error("status not busy");
    property p_refuse;
        $fell(dataOeN[0]) |-> !($past(busyIn) && $past(busyIn, 2) && $past(busyIn, 3)
            && $past(dataCommandSelect, 3) && $past(dataCommandSelect, 4));
    endproperty
    a_refuse: assert property (p_refuse) else $error("display read while busy");
    property p_pulse;
        ramReadReq |=> !ramReadReq ##0 (!$past(dataOeN[0], 2) || !$past(dataOeN[0], 3));
    endproperty
    a_pulse: assert property (p_pulse) else $error("refill request misplaced");
    property p_stall;
        wordValid && !wordReady |=> wordValid && $stable(wordData) && $stable(wordIsData);
    endproperty
    a_stall: assert property (p_stall) else $error("word lost in stall");
    property p_noword;
        (chipSelectActiveLowN && !wordValid) [*6] |=> !wordValid;
    endproperty
    a_noword: assert property (p_noword) else $error("word while deselected");
endmodule

bind lhi_host_port lhi_host_port_chk u_lhi_host_port_chk (.clock(clock), .rst(rst),
    .parallelSelect(parallelSelect), .busStyleSelect(busStyleSelect),
    .chipSelectActiveLowN(chipSelectActiveLowN), .dataCommandSelect(dataCommandSelect),
    .readStrobe(readStrobe), .dataOut(dataOut), .dataOeN(dataOeN), .wordValid(wordValid),
    .wordReady(wordReady), .wordIsData(wordIsData), .wordData(wordData), .busyIn(busyIn),
    .ramReadReq(ramReadReq));

// file: testbench/lhi_host_model.sv
// host processor model: parallel 80/68 accesses and serial bytes
// assumes the bench sets the bus style strap; pins change after clock edges
`timescale 1ns/100ps
module lhi_host_model (
    // clock and bus style
    input wire logic clock,
    input wire logic st68,
    // device side of the bus
    input wire logic [7:0] devOut,
    input wire logic [7:0] devOeN,
    // host pins
    output logic csN,
    output logic csH,
    output logic dc,
    output logic rdS,
    output logic wrS,
    output logic [7:0] bus
);
    logic drv = 1'b0;
    logic [7:0] hd = 8'h00;
    initial begin
        {csH, csN, dc, rdS, wrS} = 5'h0b;
    end
    // released lines show the inverse of the last driven value
    assign bus = !devOeN[0] ? devOut : drv ? hd : ~hd;

    task automatic acc(input logic rd, input logic dcv, input logic [1:0] cs,
            input logic [7:0] wd, output logic [8:0] r);
        @(posedge clock);
        {csH, csN} <= cs;
        dc <= dcv;
        drv <= !rd;
        hd <= wd;
        wrS <= st68 ? rd : 1'b1;
        // enable idles low in 68 style so no access starts with the select
        if (st68) rdS <= 1'b0;
        repeat (2) @(posedge clock);
        if (st68) rdS <= 1'b1; else if (rd) rdS <= 1'b0; else wrS <= 1'b0;
        repeat (6) @(posedge clock);
        r = {devOeN[0], bus};
        if (st68) rdS <= 1'b0; else {rdS, wrS} <= 2'b11;
        repeat (4) @(posedge clock);
        {csH, csN} <= 2'b01;
        wrS <= 1'b1;
        drv <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic ser(input logic dcv, input logic [7:0] b, input int n);
        @(posedge clock);
        {csH, csN} <= 2'b10;
        dc <= dcv;
        drv <= 1'b1;
        hd <= 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            repeat (5) @(posedge clock);
            hd <= {b[i], 7'h00};
            repeat (5) @(posedge clock);
            hd[6] <= 1'b1;
        end
        repeat (5) @(posedge clock);
        hd[6] <= 1'b0;
        repeat (5) @(posedge clock);
        {csH, csN} <= 2'b01;
        repeat (4) @(posedge clock);
        drv <= 1'b0;
    endtask
endmodule

// file: testbench/lhi_host_port_bench.sv
// self-checking bench of the lcd host port in parallel and serial modes
// assumes the host model drives the pins and the bench plays the display side
`timescale 1ns/100ps
module lhi_host_port_bench;
    logic clock, rst, parallelSelect, busStyleSelect, csN, csH, dc, rdS, wrS, busyIn;
    logic wordValid, wordIsData, ramReadReq, stall;
    logic wordReady = 1'b0;
    logic [7:0] bus, dataOut, dataOeN, wordData;
    logic [7:0] ramReadData = 8'h00;
    logic [7:0] expHold = 8'h00;
    logic [31:0] seed = 32'h00010757;
    logic [8:0] expQ[$];
    int n_mismatch = 0;
    int checked = 0;

    lhi_host_port u_lhi_host_port (.clock(clock), .rst(rst), .parallelSelect(parallelSelect),
        .busStyleSelect(busStyleSelect), .chipSelectActiveLowN(csN),
        .chipSelectActiveHigh(csH), .dataCommandSelect(dc), .readStrobe(rdS),
        .writeStrobe(wrS), .dataIn(bus), .dataOut(dataOut), .dataOeN(dataOeN),
        .wordValid(wordValid), .wordReady(wordReady), .wordIsData(wordIsData),
        .wordData(wordData), .busyIn(busyIn), .ramReadReq(ramReadReq),
        .ramReadData(ramReadData));
    lhi_host_model u_lhi_host_model (.clock(clock), .st68(busStyleSelect), .devOut(dataOut),
        .devOeN(dataOeN), .csN(csN), .csH(csH), .dc(dc), .rdS(rdS), .wrS(wrS), .bus(bus));

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic cmpRead(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: read got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmpWord(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: word got %h expected %h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic dcv, input logic [1:0] cs, input logic ok);
        logic [7:0] b;
        logic [8:0] r;
        b = rnd8();
        if (ok) expQ.push_back({dcv, b});
        u_lhi_host_model.acc(1'b0, dcv, cs, b, r);
    endtask

    // a set top bit of e expects the bus left undriven
    task automatic rd(input logic dcv, input logic [8:0] e);
        logic [8:0] r;
        u_lhi_host_model.acc(1'b1, dcv, 2'b10, 8'h00, r);
        if (e[8]) r[7:0] = 8'h00;
        cmpRead(r, e);
    endtask

    task automatic drain();
        for (int i = 0; i < 300 && expQ.size() > 0; i++) @(posedge clock);
        if (expQ.size() != 0) begin
            n_mismatch++;
            results();
        end
    endtask

    // display side: random stalls, memory refill, byte comparison
    always @(posedge clock) begin
        wordReady <= !stall && rnd8() > 8'h40;
        if (ramReadReq) begin
            expHold = rnd8();
            ramReadData <= expHold;
        end
        if (!rst && wordValid && wordReady)
            cmpWord({wordIsData, wordData}, expQ.size() ? expQ.pop_front() : 'x);
    end

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        logic [7:0] b;
        {rst, parallelSelect, busStyleSelect, busyIn, stall} = 5'h18;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        for (int s = 0; s < 2; s++) begin
            busStyleSelect <= s[0];
            repeat (4) @(posedge clock);
            wr(1'b0, 2'b10, 1'b1);
            wr(1'b1, 2'b10, 1'b1);
            rd(1'b0, 9'h000);
            rd(1'b1, {1'b0, expHold});
            rd(1'b1, {1'b0, expHold});
            wr(1'b1, 2'b00, 1'b0);
            wr(1'b1, 2'b11, 1'b0);
            drain();
            $display("test parallel style %0d done", s);
        end
        busyIn <= 1'b1;
        rd(1'b0, 9'h080);
        rd(1'b1, 9'h100);
        wr(1'b0, 2'b10, 1'b0);
        busyIn <= 1'b0;
        $display("test busy done");
        stall <= 1'b1;
        wr(1'b1, 2'b10, 1'b1);
        wr(1'b0, 2'b10, 1'b1);
        rd(1'b0, 9'h080);
        wr(1'b1, 2'b10, 1'b0);
        stall <= 1'b0;
        drain();
        $display("test buffer full done");
        parallelSelect <= 1'b0;
        repeat (4) @(posedge clock);
        rd(1'b0, 9'h100);
        for (int k = 0; k < 4; k++) begin
            b = rnd8();
            if (k != 2) expQ.push_back({k[0], b});
            u_lhi_host_model.ser(k[0], b, k == 2 ? 5 : 8);
        end
        drain();
        $display("test serial done");
        results();
    end
endmodule
